// file: design/rss_defs.svh
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define RSS_OFF_UNIT      8'h00
`define RSS_OFF_SITE      8'h04
`define RSS_OFF_SRC_A     8'h08
`define RSS_OFF_SRC_B     8'h0C
`define RSS_OFF_A_FLOOR   8'h10
`define RSS_OFF_A_CEIL    8'h14
`define RSS_OFF_B_FLOOR   8'h18
`define RSS_OFF_B_CEIL    8'h1C
`define RSS_OFF_AI1_MIN   8'h20
`define RSS_OFF_AI1_MAX   8'h24
`define RSS_OFF_AI2_MIN   8'h28
`define RSS_OFF_AI2_MAX   8'h2C
`define RSS_OFF_MACRO     8'h30
`define RSS_OFF_FMAX      8'h34
`define RSS_OFF_STATUS    8'h38
`define RSS_OFF_OUTREF    8'h3C

// ==========================================================================
// Reset values
`define RSS_RST_UNIT      2'h1
`define RSS_RST_SITE      4'h6
`define RSS_RST_SRC_A     4'h1
`define RSS_RST_SRC_B     4'h2
`define RSS_RST_FLOOR     16'h0000
`define RSS_RST_A_CEIL    16'h01F4
`define RSS_RST_B_CEIL    16'h03E8
`define RSS_RST_AI_MIN    10'h000
`define RSS_RST_AI_MAX    10'h3FF
`define RSS_RST_FMAX      16'h01F4

// ==========================================================================
// Encodings
`define RSS_UNIT_HZ       2'h1
`define RSS_UNIT_PCT      2'h2
`define RSS_SITE_DI_LO    4'h1
`define RSS_SITE_DI_HI    4'h5
`define RSS_SITE_A        4'h6
`define RSS_SITE_B        4'h7
`define RSS_SITE_SERIAL   4'h8
`define RSS_SRC_AI1       4'h1
`define RSS_SRC_AI2       4'h2
`define RSS_SRC_PANEL     4'h3
`define RSS_SRC_UD_R      4'h5
`define RSS_SRC_UD_34     4'h6
`define RSS_SRC_UD_45     4'h7
`define RSS_SRC_SERIAL    4'h8
`define RSS_SRC_NC_R      4'hB
`define RSS_SRC_NC_34     4'hC
`define RSS_SRC_NC_45     4'hD
`define RSS_PCT_FULL      16'h03E8

// ==========================================================================
// Timing
`define RSS_CLK_MHZ       25
`define RSS_UD_STEP_US    100
`define RSS_UD_STEP_CYC   (`RSS_UD_STEP_US * `RSS_CLK_MHZ)

`endif

// file: design/rss_pkg.sv
`include "rss_defs.svh"
`default_nettype none

package rss_pkg;

    typedef struct packed {
        logic [15:0] result;
    } rss_scale_st_t;

    typedef struct packed {
        logic        site_b;
    } rss_sel_st_t;

    typedef struct packed {
        logic [1:0]  unit;
        logic [3:0]  site;
        logic [3:0]  src_a;
        logic [3:0]  src_b;
        logic [15:0] a_floor;
        logic [15:0] a_ceil;
        logic [15:0] b_floor;
        logic [15:0] b_ceil;
        logic [9:0]  ai1_min;
        logic [9:0]  ai1_max;
        logic [9:0]  ai2_min;
        logic [9:0]  ai2_max;
        logic        macro;
        logic [15:0] fmax;
        logic [31:0] rdata;
        logic [15:0] ud;
        logic [11:0] tick;
        logic        prev_site_b;
        logic        prev_local;
        logic [15:0] last_raw;
        logic [15:0] freq;
        logic [15:0] proc;
        logic        proc_mode;
    } rss_main_st_t;

endpackage

`default_nettype wire

// file: design/rss_scale_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rss_scale_if;
    logic [9:0]  ai;
    logic [9:0]  ai_min;
    logic [9:0]  ai_max;
    logic [15:0] floor_v;
    logic [15:0] ceil_v;
    logic [15:0] result;

    modport user   (output ai, ai_min, ai_max, floor_v, ceil_v,
                    input  result);
    modport scaler (input  ai, ai_min, ai_max, floor_v, ceil_v,
                    output result);
endinterface

`default_nettype wire

// file: design/rss_scaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "rss_defs.svh"

module rss_scaler
(
    input  wire logic    sys_clk_i,
    input  wire logic    rstn_i,
    rss_scale_if.scaler  sc
);

    rss_pkg::rss_scale_st_t st_r;
    rss_pkg::rss_scale_st_t st_nxt;

    // ======================================================================
    // Linear map, input clamped to its own range
    function automatic logic [15:0] map_lin
    (
        input logic [9:0]  ai,
        input logic [9:0]  lo,
        input logic [9:0]  hi,
        input logic [15:0] fl,
        input logic [15:0] cl
    );
        logic signed [31:0] span;
        logic signed [31:0] q;
        span = $signed({16'h0000, cl}) - $signed({16'h0000, fl});
        q    = '0;
        if (ai <= lo)
        begin
            map_lin = fl;
        end
        else if (ai >= hi)
        begin
            map_lin = cl;
        end
        else
        begin
            // Span may be negative, giving a falling characteristic
            q = (span * $signed({22'h000000, 10'(ai - lo)}))
                / $signed({22'h000000, 10'(hi - lo)});
            map_lin = 16'($signed({16'h0000, fl}) + q);
        end
    endfunction

    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.result = map_lin(sc.ai, sc.ai_min, sc.ai_max,
                                sc.floor_v, sc.ceil_v);
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign sc.result = st_r.result;

    // ======================================================================
    // Checks
    a_scale_floor: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        sc.ai <= sc.ai_min |=> sc.result == $past(sc.floor_v))
        else $error("scaled value not at floor");
    a_scale_ceiling: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (sc.ai >= sc.ai_max) && (sc.ai > sc.ai_min)
        |=> sc.result == $past(sc.ceil_v))
        else $error("scaled value not at ceiling");

endmodule

`default_nettype wire

// file: design/rss_site_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "rss_defs.svh"

module rss_site_sel
(
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic [3:0] site_choice_i,
    input  wire logic [4:0] di_i,
    input  wire logic       serial_site_b_i,
    output logic            site_b_o
);

    rss_pkg::rss_sel_st_t st_r;
    rss_pkg::rss_sel_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if ((site_choice_i >= `RSS_SITE_DI_LO) &&
            (site_choice_i <= `RSS_SITE_DI_HI))
            st_nxt.site_b = di_i[3'(site_choice_i - `RSS_SITE_DI_LO)];
        else if (site_choice_i == `RSS_SITE_A)
            st_nxt.site_b = 1'b0;
        else if (site_choice_i == `RSS_SITE_B)
            st_nxt.site_b = 1'b1;
        else if (site_choice_i == `RSS_SITE_SERIAL)
            st_nxt.site_b = serial_site_b_i;
        else
            st_nxt.site_b = 1'b0;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign site_b_o = st_r.site_b;

endmodule

`default_nettype wire

// file: design/rss_ref_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "rss_defs.svh"

module rss_ref_select
(
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic        local_mode_i,
    input  wire logic [15:0] panel_ref_i,
    input  wire logic [15:0] serial_ref_i,
    input  wire logic        serial_site_b_i,
    input  wire logic [4:0]  di_i,
    input  wire logic [9:0]  ai1_i,
    input  wire logic [9:0]  ai2_i,
    output logic             site_b_o,
    output logic      [15:0] freq_ref_o,
    output logic      [15:0] process_ref_o,
    output logic             process_mode_o
);

    rss_pkg::rss_main_st_t st_r;
    rss_pkg::rss_main_st_t st_nxt;

    rss_scale_if sca ();
    rss_scale_if scb ();

    logic        site_b;
    logic [15:0] ref_a_raw;
    logic [15:0] ref_b_raw;
    logic [15:0] act_raw;
    logic [3:0]  act_src;
    logic [15:0] act_floor;
    logic [15:0] act_ceil;
    logic        ud_up;
    logic        ud_down;
    logic        copy_evt;
    logic        tick_hit;

    // ======================================================================
    // Helpers
    function automatic logic is_ud(input logic [3:0] s);
        is_ud = (s == `RSS_SRC_UD_R) || (s == `RSS_SRC_UD_34) ||
                (s == `RSS_SRC_UD_45) || (s == `RSS_SRC_NC_R) ||
                (s == `RSS_SRC_NC_34) || (s == `RSS_SRC_NC_45);
    endfunction

    function automatic logic is_nc(input logic [3:0] s);
        is_nc = (s == `RSS_SRC_NC_R) || (s == `RSS_SRC_NC_34) ||
                (s == `RSS_SRC_NC_45);
    endfunction

    function automatic logic [15:0] pct_to_hz
    (
        input logic [15:0] v,
        input logic [15:0] f
    );
        logic [31:0] p;
        p = {16'h0000, v} * {16'h0000, f};
        pct_to_hz = 16'(p / {16'h0000, `RSS_PCT_FULL});
    endfunction

    function automatic logic [15:0] pick_src
    (
        input logic [3:0]  s,
        input logic [15:0] ai_v,
        input logic [15:0] ud_v,
        input logic [15:0] pnl,
        input logic [15:0] ser
    );
        if ((s == `RSS_SRC_AI1) || (s == `RSS_SRC_AI2))
            pick_src = ai_v;
        else if (s == `RSS_SRC_PANEL)
            pick_src = pnl;
        else if (s == `RSS_SRC_SERIAL)
            pick_src = ser;
        else if (is_ud(s))
            pick_src = ud_v;
        else
            pick_src = 16'h0000;
    endfunction

    // ======================================================================
    // Site selection and scaling
    rss_site_sel u_site
    (
        .sys_clk_i       (sys_clk_i),
        .rstn_i          (rstn_i),
        .site_choice_i   (st_r.site),
        .di_i            (di_i),
        .serial_site_b_i (serial_site_b_i),
        .site_b_o        (site_b)
    );

    // Each scaler takes the range of whichever analog input feeds it
    assign sca.ai      = (st_r.src_a == `RSS_SRC_AI2) ? ai2_i
                                                       : ai1_i;
    assign sca.ai_min  = (st_r.src_a == `RSS_SRC_AI2) ? st_r.ai2_min
                                                       : st_r.ai1_min;
    assign sca.ai_max  = (st_r.src_a == `RSS_SRC_AI2) ? st_r.ai2_max
                                                       : st_r.ai1_max;
    assign sca.floor_v = st_r.a_floor;
    assign sca.ceil_v  = st_r.a_ceil;
    assign scb.ai      = (st_r.src_b == `RSS_SRC_AI2) ? ai2_i
                                                       : ai1_i;
    assign scb.ai_min  = (st_r.src_b == `RSS_SRC_AI2) ? st_r.ai2_min
                                                       : st_r.ai1_min;
    assign scb.ai_max  = (st_r.src_b == `RSS_SRC_AI2) ? st_r.ai2_max
                                                       : st_r.ai1_max;
    assign scb.floor_v = st_r.b_floor;
    assign scb.ceil_v  = st_r.b_ceil;

    rss_scaler u_scale_a
    (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .sc        (sca)
    );

    rss_scaler u_scale_b
    (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .sc        (scb)
    );

    // ======================================================================
    // Source values and up/down control
    assign ref_a_raw = pick_src(st_r.src_a, sca.result, st_r.ud,
                                panel_ref_i, serial_ref_i);
    assign ref_b_raw = pick_src(st_r.src_b, scb.result, st_r.ud,
                                panel_ref_i, serial_ref_i);
    assign act_src   = local_mode_i ? 4'h0
                     : (site_b ? st_r.src_b : st_r.src_a);
    assign act_floor = site_b ? st_r.b_floor : st_r.a_floor;
    assign act_ceil  = site_b ? st_r.b_ceil : st_r.a_ceil;
    assign act_raw   = local_mode_i ? panel_ref_i
                     : (site_b ? ref_b_raw : ref_a_raw);
    assign ud_up     = ((act_src == `RSS_SRC_UD_45) ||
                        (act_src == `RSS_SRC_NC_45)) ? di_i[3] : di_i[2];
    assign ud_down   = ((act_src == `RSS_SRC_UD_45) ||
                        (act_src == `RSS_SRC_NC_45)) ? di_i[4] : di_i[3];
    assign copy_evt  = !local_mode_i &&
                       ((site_b != st_r.prev_site_b) || st_r.prev_local);
    assign tick_hit  = st_r.tick == 12'(`RSS_UD_STEP_CYC - 1);

    // ======================================================================
    // Next state
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.rdata = 32'h0000_0000;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `RSS_OFF_UNIT:    st_nxt.unit    = reg_wdata_i[1:0];
                `RSS_OFF_SITE:    st_nxt.site    = reg_wdata_i[3:0];
                `RSS_OFF_SRC_A:   st_nxt.src_a   = reg_wdata_i[3:0];
                `RSS_OFF_SRC_B:   st_nxt.src_b   = reg_wdata_i[3:0];
                `RSS_OFF_A_FLOOR: st_nxt.a_floor = reg_wdata_i[15:0];
                `RSS_OFF_A_CEIL:  st_nxt.a_ceil  = reg_wdata_i[15:0];
                `RSS_OFF_B_FLOOR: st_nxt.b_floor = reg_wdata_i[15:0];
                `RSS_OFF_B_CEIL:  st_nxt.b_ceil  = reg_wdata_i[15:0];
                `RSS_OFF_AI1_MIN: st_nxt.ai1_min = reg_wdata_i[9:0];
                `RSS_OFF_AI1_MAX: st_nxt.ai1_max = reg_wdata_i[9:0];
                `RSS_OFF_AI2_MIN: st_nxt.ai2_min = reg_wdata_i[9:0];
                `RSS_OFF_AI2_MAX: st_nxt.ai2_max = reg_wdata_i[9:0];
                `RSS_OFF_MACRO:   st_nxt.macro   = reg_wdata_i[0];
                `RSS_OFF_FMAX:    st_nxt.fmax    = reg_wdata_i[15:0];
                default:          st_nxt.unit    = st_r.unit;
            endcase
        end
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `RSS_OFF_UNIT:    st_nxt.rdata = 32'(st_r.unit);
                `RSS_OFF_SITE:    st_nxt.rdata = 32'(st_r.site);
                `RSS_OFF_SRC_A:   st_nxt.rdata = 32'(st_r.src_a);
                `RSS_OFF_SRC_B:   st_nxt.rdata = 32'(st_r.src_b);
                `RSS_OFF_A_FLOOR: st_nxt.rdata = 32'(st_r.a_floor);
                `RSS_OFF_A_CEIL:  st_nxt.rdata = 32'(st_r.a_ceil);
                `RSS_OFF_B_FLOOR: st_nxt.rdata = 32'(st_r.b_floor);
                `RSS_OFF_B_CEIL:  st_nxt.rdata = 32'(st_r.b_ceil);
                `RSS_OFF_AI1_MIN: st_nxt.rdata = 32'(st_r.ai1_min);
                `RSS_OFF_AI1_MAX: st_nxt.rdata = 32'(st_r.ai1_max);
                `RSS_OFF_AI2_MIN: st_nxt.rdata = 32'(st_r.ai2_min);
                `RSS_OFF_AI2_MAX: st_nxt.rdata = 32'(st_r.ai2_max);
                `RSS_OFF_MACRO:   st_nxt.rdata = 32'(st_r.macro);
                `RSS_OFF_FMAX:    st_nxt.rdata = 32'(st_r.fmax);
                `RSS_OFF_STATUS:  st_nxt.rdata = 32'({st_r.proc_mode,
                                                      local_mode_i,
                                                      site_b});
                `RSS_OFF_OUTREF:  st_nxt.rdata = {st_r.proc, st_r.freq};
                default:          st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Step timer paces the up/down ramp at one count per 2500 clocks (100 us at 25 MHz)
        st_nxt.tick = tick_hit ? 12'h000 : 12'(st_r.tick + 12'h001);
        if (copy_evt && is_ud(act_src) && !is_nc(act_src))
        begin
            // Bumpless takeover: start from the last active value
            st_nxt.ud = st_r.last_raw;
        end
        else if (tick_hit && is_ud(act_src))
        begin
            if (ud_up && !ud_down && (st_r.ud < act_ceil))
                st_nxt.ud = 16'(st_r.ud + 16'h0001);
            else if (ud_down && !ud_up && (st_r.ud > act_floor))
                st_nxt.ud = 16'(st_r.ud - 16'h0001);
        end

        st_nxt.proc_mode = 1'b0;
        st_nxt.proc      = 16'h0000;
        if (local_mode_i && (st_r.unit != `RSS_UNIT_PCT))
        begin
            st_nxt.freq = panel_ref_i;
        end
        else if (local_mode_i || site_b)
        begin
            if (st_r.macro)
            begin
                // Speed stays zero while the process loop owns it
                st_nxt.proc_mode = 1'b1;
                st_nxt.proc      = act_raw;
                st_nxt.freq      = 16'h0000;
            end
            else
            begin
                st_nxt.freq = pct_to_hz(act_raw,
                                        st_r.fmax);
            end
        end
        else
        begin
            st_nxt.freq = ref_a_raw;
        end
        st_nxt.last_raw    = act_raw;
        st_nxt.prev_site_b = site_b;
        st_nxt.prev_local  = local_mode_i;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_r         <= '0;
            st_r.unit    <= `RSS_RST_UNIT;
            st_r.site    <= `RSS_RST_SITE;
            st_r.src_a   <= `RSS_RST_SRC_A;
            st_r.src_b   <= `RSS_RST_SRC_B;
            st_r.a_floor <= `RSS_RST_FLOOR;
            st_r.a_ceil  <= `RSS_RST_A_CEIL;
            st_r.b_floor <= `RSS_RST_FLOOR;
            st_r.b_ceil  <= `RSS_RST_B_CEIL;
            st_r.ai1_min <= `RSS_RST_AI_MIN;
            st_r.ai1_max <= `RSS_RST_AI_MAX;
            st_r.ai2_min <= `RSS_RST_AI_MIN;
            st_r.ai2_max <= `RSS_RST_AI_MAX;
            st_r.fmax    <= `RSS_RST_FMAX;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o    = st_r.rdata;
    assign site_b_o       = site_b;
    assign freq_ref_o     = st_r.freq;
    assign process_ref_o  = st_r.proc;
    assign process_mode_o = st_r.proc_mode;

    // ======================================================================
    // Checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_local_hz_path: assert property (local_mode_i &&
        (st_r.unit == `RSS_UNIT_HZ) |=> freq_ref_o == $past(panel_ref_i))
        else $error("panel hertz value not passed");
    a_local_pct_path: assert property (local_mode_i &&
        (st_r.unit == `RSS_UNIT_PCT) && !st_r.macro
        |=> freq_ref_o == pct_to_hz($past(panel_ref_i), $past(st_r.fmax)))
        else $error("panel percent value not converted");
    a_site_di_follow: assert property (
        (st_r.site >= `RSS_SITE_DI_LO) && (st_r.site <= `RSS_SITE_DI_HI)
        |=> site_b_o == $past(di_i[3'(st_r.site - `RSS_SITE_DI_LO)]))
        else $error("site does not follow digital input");
    a_site_fixed_a: assert property (st_r.site == `RSS_SITE_A
        |=> !site_b_o)
        else $error("site not fixed to first");
    a_site_fixed_b: assert property (st_r.site == `RSS_SITE_B
        |=> site_b_o)
        else $error("site not fixed to second");
    a_site_serial_pick: assert property (
        st_r.site == `RSS_SITE_SERIAL |=> site_b_o == $past(serial_site_b_i))
        else $error("site does not follow serial master");
    a_site_a_source: assert property (
        !local_mode_i && !site_b && (st_r.src_a == `RSS_SRC_PANEL)
        |=> freq_ref_o == $past(panel_ref_i) && !process_mode_o)
        else $error("first site source not followed");
    a_ud_copy_load: assert property (
        copy_evt && is_ud(act_src) && !is_nc(act_src)
        |=> st_r.ud == $past(st_r.last_raw))
        else $error("up/down value not copied");
    a_ud_no_copy: assert property (copy_evt && is_nc(act_src) &&
        !tick_hit |=> st_r.ud == $past(st_r.ud))
        else $error("up/down value copied on no-copy source");
    a_process_ref: assert property (
        !local_mode_i && site_b && st_r.macro
        |=> process_mode_o && (process_ref_o == $past(ref_b_raw))
            && (freq_ref_o == 16'h0000))
        else $error("process reference not routed");
    a_pct_of_fmax: assert property (
        !local_mode_i && site_b && !st_r.macro
        |=> freq_ref_o == pct_to_hz($past(ref_b_raw), $past(st_r.fmax)))
        else $error("second reference not scaled to fmax");

    c_local_percent: cover property (local_mode_i &&
        (st_r.unit == `RSS_UNIT_PCT) ##1 !local_mode_i);
    c_site_switch: cover property (!site_b ##1 site_b);
    c_copy_event: cover property (copy_evt && is_ud(act_src));
    c_process_mode: cover property (process_mode_o ##1 !process_mode_o);

endmodule

`default_nettype wire

// file: dv/rss_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Panel, terminals and serial master
// Each value lands one clock late: the far side samples on the same system clock edge
module rss_far_side
(
    input  wire logic        sys_clk_i,
    input  wire logic [42:0] set_i,
    output logic      [42:0] far_o = 43'h0
);
    always @(posedge sys_clk_i)
    begin
        far_o <= set_i;
    end
endmodule
`default_nettype wire

// file: dv/reference_source_selector_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module reference_source_selector_bench;
    // ==========================================
    // Stimulus and partner
    logic        sys_clk_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic [31:0] wdata     = 32'h0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        rd_d      = 1'b0;
    logic [7:0]  a_d       = 8'h00;
    logic        site_o;
    logic [15:0] freq_o;
    logic [15:0] proc_o;
    logic        mode_o;
    logic [15:0] r;
    logic        l         = 1'b0;
    logic        s         = 1'b0;
    logic        e;
    logic [15:0] p         = 16'h0;
    logic [4:0]  d         = 5'h0;
    logic [9:0]  a1        = 10'h0;
    logic [9:0]  a2        = 10'h0;
    logic [31:0] rdata;
    logic [31:0] x;
    logic [42:0] f;
    logic [31:0] q[$];
    integer      seed = 7954;
    integer      num_errors = 0;
    integer      checked = 0;
    integer      c;
    wire  [42:0] set_v = {l, p, s, d, a1, a2};

    rss_far_side i_rss_far_side (.sys_clk_i(sys_clk_i), .set_i(set_v),
        .far_o(f));
    rss_ref_select i_rss_ref_select (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .local_mode_i(f[42]),
        .panel_ref_i(f[41:26]), .serial_ref_i(f[41:26]),
        .serial_site_b_i(f[25]), .di_i(f[24:20]), .ai1_i(f[19:10]),
        .ai2_i(f[9:0]), .site_b_o(site_o), .freq_ref_o(freq_o),
        .process_ref_o(proc_o), .process_mode_o(mode_o));

    // ==========================================
    // Bus tasks
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask

    // Waits past the two-cycle analog path plus the partner's own clock
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] v);
        repeat (6) @(posedge sys_clk_i);
        rd <= 1'b1;
        addr <= a;
        q.push_back(v);
        @(posedge sys_clk_i);
        rd <= 1'b0;
    endtask

    task automatic wrap_up;
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================
    // Watcher: read data stands only in the cycle after the strobe
    always @(posedge sys_clk_i)
    begin
        rd_d <= rd;
        a_d  <= addr;
    end
    always @(negedge sys_clk_i)
    begin
        if (rd_d)
        begin
            x = q.pop_front();
            `CHK(rdata, x)
            // Output pins must agree with the note as well
            if (a_d == 8'h3C)
                `CHK({proc_o, freq_o}, x)
            if (a_d == 8'h38)
                `CHK({mode_o, site_o}, {x[2], x[0]})
        end
    end

    initial
    begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk_i);
        num_errors++;
        wrap_up;
    end

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        rd_reg(8'h0C, 32'h2);
        rd_reg(8'h40, 32'h0);
        rd_reg(8'h3C, 32'h0);
        l <= 1'b1;
        r = {4'h0, 12'($random(seed))};
        p <= r;
        rd_reg(8'h3C, {16'h0, r});
        wr_reg(8'h00, 32'h2);
        rd_reg(8'h3C, 32'(p) * 500 / 1000);
        rd_reg(8'h38, 32'h2);
        l <= 1'b0;
        for (c = 1; c <= 8; c++)
        begin
            d <= 5'($random(seed));
            s <= 1'($random(seed));
            wr_reg(8'h04, 32'(c));
            e = (c <= 5) ? d[c-1] : (c == 7) || (c == 8 && s);
            rd_reg(8'h38, {31'h0, e});
        end
        wr_reg(8'h04, 32'h6);
        wr_reg(8'h10, 32'h64);
        a1 <= 10'h3FF;
        rd_reg(8'h3C, 32'h1F4);
        a1 <= 10'h200;
        rd_reg(8'h3C, 32'h12C);
        wr_reg(8'h20, 32'h100);
        a1 <= 10'h080;
        rd_reg(8'h3C, 32'h64);
        wr_reg(8'h04, 32'h7);
        wr_reg(8'h18, 32'hC8);
        rd_reg(8'h3C, 32'h64);
        a2 <= 10'h3FF;
        rd_reg(8'h3C, 32'h1F4);
        wr_reg(8'h30, 32'h1);
        rd_reg(8'h3C, 32'h03E80000);
        rd_reg(8'h38, 32'h5);
        // Up/down inputs quiet so the shared value cannot ramp
        d <= 5'h00;
        wr_reg(8'h08, 32'h3);
        wr_reg(8'h04, 32'h6);
        rd_reg(8'h3C, {16'h0, r});
        wr_reg(8'h0C, 32'h5);
        wr_reg(8'h04, 32'h7);
        rd_reg(8'h3C, {r, 16'h0});
        wr_reg(8'h0C, 32'hC);
        wr_reg(8'h04, 32'h6);
        p <= r ^ 16'h0100;
        wr_reg(8'h04, 32'h7);
        rd_reg(8'h3C, {r, 16'h0});
        repeat (4) @(posedge sys_clk_i);
        wrap_up;
    end
endmodule
`default_nettype wire
